// File: hw/dpt_pkg.sv
// dpt_pkg: register map, field positions and reset values of the
// dual programmable timer control block.
// assumes an 8-bit register port with 16-bit byte addresses.
package dpt_pkg;
    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int DPT_AW = 16;
    localparam int DPT_DW = 8;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [15:0] DPT_FLAGS_ADDR = 16'hff28;
    localparam logic [15:0] DPT_CTRL0_ADDR = 16'hff30;
    localparam logic [15:0] DPT_CTRL1_ADDR = 16'hff31;
    localparam logic [15:0] DPT_RL0_ADDR   = 16'hff32;
    localparam logic [15:0] DPT_RL1_ADDR   = 16'hff33;
    localparam logic [15:0] DPT_CMP0_ADDR  = 16'hff34;
    localparam logic [15:0] DPT_CMP1_ADDR  = 16'hff35;
    localparam logic [15:0] DPT_CNT0_ADDR  = 16'hff36;
    localparam logic [15:0] DPT_CNT1_ADDR  = 16'hff37;
    localparam logic [15:0] DPT_MASK_ADDR  = 16'hff3a;

    // ------------------------------------------------------------
    // control fields
    // ------------------------------------------------------------
    localparam int DPT_CTL_WIDTH16 = 7;
    localparam int DPT_CTL_GATE    = 3;
    localparam int DPT_CTL_RUN     = 2;
    localparam int DPT_CTL_LOAD    = 1;
    localparam int DPT_CTL_SRC     = 0;

    // ------------------------------------------------------------
    // flag fields
    // ------------------------------------------------------------
    localparam int DPT_FLG_UF0 = 3;
    localparam int DPT_FLG_CM0 = 4;
    localparam int DPT_FLG_UF1 = 5;
    localparam int DPT_FLG_CM1 = 6;

    // ------------------------------------------------------------
    // reset values and register-file indices
    // ------------------------------------------------------------
    localparam logic [7:0] DPT_RL_RST   = 8'hff;
    localparam logic [7:0] DPT_CMP_RST  = 8'h00;
    localparam logic [7:0] DPT_CNT_RST  = 8'hff;
    localparam logic [7:0] DPT_ZERO     = 8'h00;
    localparam logic [1:0] DPT_RF_RL0   = 2'h0;
    localparam logic [1:0] DPT_RF_RL1   = 2'h1;
    localparam logic [1:0] DPT_RF_CMP0  = 2'h2;
    localparam logic [1:0] DPT_RF_CMP1  = 2'h3;
endpackage

// File: hw/dpt_regfile.sv
// dpt_regfile: reload and compare bytes of both timers.
// assumes one write port on the core clock; read data are registered.
`timescale 1ns/1ps
module dpt_regfile
    import dpt_pkg::*;
#(
    parameter int W = DPT_DW
)
(
    input  wire logic           core_clk,
    input  wire logic           sys_rst,
    input  wire logic           ce,
    input  wire logic           we,
    input  wire logic [1:0]     waddr,
    input  wire logic [W-1:0]   wdata,
    input  wire logic [1:0]     raddr,
    output logic      [W-1:0]   rdata_q,
    output logic      [4*W-1:0] words
);
    logic [W-1:0] mem_q [4];

    // reload words reset high, compare words low
    function automatic logic [W-1:0] rst_val(input int idx);
        rst_val = (idx < 2) ? W'(DPT_RL_RST) : W'(DPT_CMP_RST);
    endfunction

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            for (int i = 0; i < 4; i++)
                mem_q[i] <= rst_val(i);
            rdata_q <= '0;
        end
        else if (ce)
        begin
            if (we)
                mem_q[waddr] <= wdata;
            rdata_q <= mem_q[raddr];
        end
    end

    assign words = {mem_q[3], mem_q[2], mem_q[1], mem_q[0]};
endmodule

// File: hw/dpt_timer.sv
// dpt_timer: two 8-bit down counters, cascadable to 16 bits, with
// control registers, factor flags, clock outputs and one interrupt.
// assumes a register master on core_clk and asynchronous clock pins.
//
// Functional notes
// [R1] control-0 bit 7 set cascades both timers into one 16-bit counter, clear runs two 8-bit timers, reset clear.
// [R2] control bit 3 of each timer lets its clock output run when set and holds it low when clear, reset clear.
// [R3] control bit 2 of each timer lets the counter count when set and halts it when clear, reset clear; timer 1 bit 2 ignored when cascaded.
// [R4] control bit 0 of each timer picks the external clock pin when set and the internal tick when clear, reset clear; timer 1 bit 0 ignored when cascaded.
// [R5] a compare match sets flag bit 4 for timer 0 and flag bit 6 for timer 1.
// [R6] an underflow sets flag bit 3 for timer 0 and flag bit 5 for timer 1, all four flags reset clear.
// [R7] writing 1 to a flag clears it and writing 0 leaves it alone.
// [R8] writing 1 to control bit 1 loads the reload value into the counter, bit 1 and bits 6..4 read 0.
// [R9] in cascaded mode timer 0 registers hold the low byte and timer 1 registers the high byte.
`timescale 1ns/1ps
module dpt_timer
    import dpt_pkg::*;
#(
    parameter int W = DPT_DW
)
(
    input  wire logic              core_clk,
    input  wire logic              sys_rst,
    input  wire logic              ce,
    input  wire logic [DPT_AW-1:0] addr,
    input  wire logic [W-1:0]      wdata,
    input  wire logic              wr,
    input  wire logic              rd,
    output logic      [W-1:0]      rdata,
    input  wire logic              int_tick,
    input  wire logic [1:0]        ext_clk,
    output logic      [1:0]        tout,
    output logic                   irq
);
    // ------------------------------------------------------------
    // register decode
    // ------------------------------------------------------------
    wire wr_flags = wr & (addr == DPT_FLAGS_ADDR);
    wire wr_ctrl0 = wr & (addr == DPT_CTRL0_ADDR);
    wire wr_ctrl1 = wr & (addr == DPT_CTRL1_ADDR);
    wire wr_mask  = wr & (addr == DPT_MASK_ADDR);
    wire in_rf    = (addr >= DPT_RL0_ADDR) & (addr <= DPT_CMP1_ADDR);
    wire [1:0] rf_idx = 2'(addr - DPT_RL0_ADDR);

    // write-only load bits: one-cycle pulses, never stored
    wire load0 = wr_ctrl0 & wdata[DPT_CTL_LOAD];
    wire load1 = wr_ctrl1 & wdata[DPT_CTL_LOAD];

    // ------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------
    logic       width16_q;
    logic [1:0] gate_q;
    logic [1:0] run_q;
    logic [1:0] src_q;
    logic [W-1:0] mask_q;

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            width16_q <= 1'b0;
            gate_q    <= 2'b00;
            run_q     <= 2'b00;
            src_q     <= 2'b00;
            mask_q    <= '0;
        end
        else if (ce)
        begin
            if (wr_ctrl0)
            begin
                width16_q <= wdata[DPT_CTL_WIDTH16];
                gate_q[0] <= wdata[DPT_CTL_GATE];
                run_q[0]  <= wdata[DPT_CTL_RUN];
                src_q[0]  <= wdata[DPT_CTL_SRC];
            end
            if (wr_ctrl1)
            begin
                gate_q[1] <= wdata[DPT_CTL_GATE];
                run_q[1]  <= wdata[DPT_CTL_RUN];
                src_q[1]  <= wdata[DPT_CTL_SRC];
            end
            if (wr_mask)
                mask_q <= wdata;
        end
    end

    // ------------------------------------------------------------
    // reload and compare storage
    // ------------------------------------------------------------
    logic [4*W-1:0] rf_words;
    logic [W-1:0]   rf_rdata;

    dpt_regfile #(.W(W)) dpt_regfile_inst (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .ce       (ce),
        .we       (wr & in_rf),
        .waddr    (rf_idx),
        .wdata    (wdata),
        .raddr    (rf_idx),
        .rdata_q  (rf_rdata),
        .words    (rf_words)
    );

    wire [W-1:0] rl0  = rf_words[W-1:0];
    wire [W-1:0] rl1  = rf_words[2*W-1:W];
    wire [W-1:0] cmp0 = rf_words[3*W-1:2*W];
    wire [W-1:0] cmp1 = rf_words[4*W-1:3*W];

    // ------------------------------------------------------------
    // external clock pins
    // ------------------------------------------------------------
    logic [1:0] pin1_q;
    logic [1:0] pin2_q;
    logic [1:0] pin3_q;

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            pin1_q <= 2'b00;
            pin2_q <= 2'b00;
            pin3_q <= 2'b00;
        end
        else if (ce)
        begin
            pin1_q <= ext_clk;
            pin2_q <= pin1_q;
            pin3_q <= pin2_q;
        end
    end

    wire [1:0] ext_rise = pin2_q & ~pin3_q;

    // ------------------------------------------------------------
    // count stepping
    // ------------------------------------------------------------
    logic [W-1:0] cnt0_q;
    logic [W-1:0] cnt1_q;
    logic [W-1:0] cnt0_d;
    logic [W-1:0] cnt1_d;

    function automatic logic [W-1:0] dec(input logic [W-1:0] v);
        dec = W'(v - 1'b1);
    endfunction

    wire tick0 = src_q[0] ? ext_rise[0] : int_tick;   // see [R4]
    wire tick1 = src_q[1] ? ext_rise[1] : int_tick;   // see [R4]
    wire step0 = run_q[0] & tick0;                    // see [R3]
    wire step1 = width16_q ? (step0 & (cnt0_q == '0)) // see [R1]
                           : (run_q[1] & tick1);      // see [R3]
    wire uf0   = step0 & (cnt0_q == '0);
    wire uf1   = step1 & (cnt1_q == '0);
    wire wrap0 = width16_q ? uf1 : uf0;               // see [R1]
    wire ld0   = load0 | (width16_q & load1);         // see [R8] [R9]
    wire ld1   = load1 | (width16_q & load0);         // see [R8] [R9]

    // match on the count about to be entered
    wire m0 = step0 & ~uf0 & (dec(cnt0_q) == cmp0);
    wire m1 = width16_q
            ? (step0 & ~uf1 & ({cnt1_d, cnt0_d} == {cmp1, cmp0})) // see [R9]
            : (step1 & ~uf1 & (dec(cnt1_q) == cmp1));

    always_comb
    begin
        cnt0_d = cnt0_q;
        if (ld0 | wrap0)
            cnt0_d = rl0;                             // see [R8]
        else if (step0)
            cnt0_d = dec(cnt0_q);
        cnt1_d = cnt1_q;
        if (ld1 | uf1)
            cnt1_d = rl1;                             // see [R9]
        else if (step1)
            cnt1_d = dec(cnt1_q);
    end

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            cnt0_q <= DPT_CNT_RST;
            cnt1_q <= DPT_CNT_RST;
        end
        else if (ce)
        begin
            cnt0_q <= cnt0_d;
            cnt1_q <= cnt1_d;
        end
    end

    // ------------------------------------------------------------
    // clock outputs
    // ------------------------------------------------------------
    logic [1:0] tog_q;
    wire  [1:0] tog_ev = {uf1, width16_q ? uf1 : uf0};

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            tog_q <= 2'b00;
        else if (ce)
            tog_q <= gate_q & (tog_q ^ tog_ev);       // see [R2]
    end

    assign tout = tog_q;

    // ------------------------------------------------------------
    // factor flags and interrupt
    // ------------------------------------------------------------
    logic [W-1:0] flags_q;
    logic [W-1:0] set_v;
    logic [W-1:0] clr_v;

    always_comb
    begin
        set_v = '0;
        set_v[DPT_FLG_CM0] = m0;                      // see [R5]
        set_v[DPT_FLG_CM1] = m1;                      // see [R5]
        set_v[DPT_FLG_UF0] = uf0;                     // see [R6]
        set_v[DPT_FLG_UF1] = uf1;                     // see [R6]
        clr_v = wr_flags ? wdata : '0;
    end

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            flags_q <= '0;
        else if (ce)
            flags_q <= (flags_q & ~clr_v) | set_v;    // see [R7]
    end

    assign irq = |(flags_q & mask_q);

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    logic [W-1:0] rd_mux;
    logic [W-1:0] rdreg_q;
    logic         rf_sel_q;

    always_comb
    begin
        rd_mux = '0;
        case (addr)
            DPT_FLAGS_ADDR: rd_mux = flags_q;
            DPT_CTRL0_ADDR:
            begin
                rd_mux[DPT_CTL_WIDTH16] = width16_q;
                rd_mux[DPT_CTL_GATE]    = gate_q[0];
                rd_mux[DPT_CTL_RUN]     = run_q[0];
                rd_mux[DPT_CTL_SRC]     = src_q[0];    // see [R8]
            end
            DPT_CTRL1_ADDR:
            begin
                rd_mux[DPT_CTL_GATE] = gate_q[1];
                rd_mux[DPT_CTL_RUN]  = run_q[1];
                rd_mux[DPT_CTL_SRC]  = src_q[1];
            end
            DPT_CNT0_ADDR:  rd_mux = cnt0_q;
            DPT_CNT1_ADDR:  rd_mux = cnt1_q;
            DPT_MASK_ADDR:  rd_mux = mask_q;
            default:        rd_mux = '0;
        endcase
    end

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            rdreg_q  <= '0;
            rf_sel_q <= 1'b0;
        end
        else if (ce)
        begin
            rdreg_q  <= rd ? rd_mux : '0;
            rf_sel_q <= rd & in_rf;
        end
    end

    assign rdata = rf_sel_q ? rf_rdata : rdreg_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_carry;
        ce & width16_q & uf0 & ~uf1 & ~ld1;
    endsequence

    property p_cascade;
        @(posedge core_clk) disable iff (sys_rst)
        s_carry |=> cnt1_q == dec($past(cnt1_q));
    endproperty
    a_cascade: assert property (p_cascade) // see [R1]
        else $error("high byte did not take the carry");

    property p_gate_off;
        @(posedge core_clk) disable iff (sys_rst)
        ce & ~gate_q[1] |=> ~tout[1];
    endproperty
    a_gate_off: assert property (p_gate_off) // see [R2]
        else $error("clock output ran while gated off");

    property p_stop;
        @(posedge core_clk) disable iff (sys_rst)
        ce & ~run_q[0] & ~ld0 & ~wrap0 |=> cnt0_q == $past(cnt0_q);
    endproperty
    a_stop: assert property (p_stop) // see [R3]
        else $error("stopped timer 0 counted");

    property p_src_ext;
        @(posedge core_clk) disable iff (sys_rst)
        ce & ~width16_q & run_q[1] & src_q[1] & ~ext_rise[1] & ~ld1
            |=> $stable(cnt1_q);
    endproperty
    a_src_ext: assert property (p_src_ext) // see [R4]
        else $error("timer 1 counted without a pin edge");

    property p_match;
        @(posedge core_clk) disable iff (sys_rst)
        ce & ~width16_q & run_q[0] & tick0 & (cnt0_q != '0)
            & (dec(cnt0_q) == cmp0) |=> flags_q[DPT_FLG_CM0];
    endproperty
    a_match: assert property (p_match) // see [R5]
        else $error("compare match flag missing");

    sequence s_under;
        ce & ~width16_q & ~load1 & run_q[1] & tick1 & (cnt1_q == '0);
    endsequence

    property p_under;
        @(posedge core_clk) disable iff (sys_rst)
        s_under |=> flags_q[DPT_FLG_UF1] & (cnt1_q == $past(rl1));
    endproperty
    a_under: assert property (p_under) // see [R6]
        else $error("underflow flag or reload missing");

    property p_w1c;
        @(posedge core_clk) disable iff (sys_rst)
        ce & wr_flags & wdata[DPT_FLG_CM0] & ~m0 |=> ~flags_q[DPT_FLG_CM0];
    endproperty
    a_w1c: assert property (p_w1c) // see [R7]
        else $error("write of one did not clear the flag");

    property p_w0_keep;
        @(posedge core_clk) disable iff (sys_rst)
        ce & wr_flags & ~wdata[DPT_FLG_UF0] & flags_q[DPT_FLG_UF0]
            |=> flags_q[DPT_FLG_UF0];
    endproperty
    a_w0_keep: assert property (p_w0_keep) // see [R7]
        else $error("write of zero cleared a flag");

    property p_load;
        @(posedge core_clk) disable iff (sys_rst)
        ce & load0 & ~(wr & in_rf) |=> cnt0_q == $past(rl0);
    endproperty
    a_load: assert property (p_load) // see [R8]
        else $error("load did not copy the reload value");

    property p_ctl_read;
        @(posedge core_clk) disable iff (sys_rst)
        ce & rd & (addr == DPT_CTRL0_ADDR)
            |=> (rdata[6:4] == 3'h0) & ~rdata[DPT_CTL_LOAD];
    endproperty
    a_ctl_read: assert property (p_ctl_read) // see [R8]
        else $error("unused control bits read nonzero");

    property p_load16;
        @(posedge core_clk) disable iff (sys_rst)
        ce & width16_q & load0 & ~(wr & in_rf)
            |=> {cnt1_q, cnt0_q} == {$past(rl1), $past(rl0)};
    endproperty
    a_load16: assert property (p_load16) // see [R9]
        else $error("cascaded load byte order wrong");
endmodule

// File: tb/testbench.sv
// testbench: self-checking bench for the dual programmable timer block.
// assumes dpt_pkg and dpt_timer are compiled first; drives every port itself.
`timescale 1ns/1ps
module testbench
    import dpt_pkg::*;
;
    logic              core_clk;
    logic              sys_rst;
    logic              ce;
    logic [DPT_AW-1:0] addr;
    logic [7:0]        wdata;
    logic              wr;
    logic              rd;
    logic [7:0]        rdata;
    logic              int_tick;
    logic [1:0]        ext_clk;
    logic [1:0]        tout;
    logic              irq;
    int                num_errors;
    int                compares;

    typedef struct packed {
        logic [15:0] a;
        logic        w;
        logic [7:0]  d;
        logic [7:0]  e;
    } dpt_row_t;

    // first 11 rows are reads only and hold the reset image
    dpt_row_t rows [0:23] = '{
        {DPT_FLAGS_ADDR, 1'b0, 8'h00, 8'h00},
        {DPT_CTRL0_ADDR, 1'b0, 8'h00, 8'h00},
        {DPT_CTRL1_ADDR, 1'b0, 8'h00, 8'h00},
        {DPT_RL0_ADDR,   1'b0, 8'h00, 8'hff},
        {DPT_RL1_ADDR,   1'b0, 8'h00, 8'hff},
        {DPT_CMP0_ADDR,  1'b0, 8'h00, 8'h00},
        {DPT_CMP1_ADDR,  1'b0, 8'h00, 8'h00},
        {DPT_CNT0_ADDR,  1'b0, 8'h00, 8'hff},
        {DPT_CNT1_ADDR,  1'b0, 8'h00, 8'hff},
        {DPT_MASK_ADDR,  1'b0, 8'h00, 8'h00},
        {16'hff20,       1'b0, 8'h00, 8'h00},
        {DPT_CTRL0_ADDR, 1'b1, 8'hff, 8'h8d},
        {DPT_CTRL0_ADDR, 1'b1, 8'h00, 8'h00},
        {DPT_CTRL1_ADDR, 1'b1, 8'hff, 8'h0d},
        {DPT_CTRL1_ADDR, 1'b1, 8'h00, 8'h00},
        {DPT_RL0_ADDR,   1'b1, 8'ha5, 8'ha5},
        {DPT_RL1_ADDR,   1'b1, 8'h5a, 8'h5a},
        {DPT_CMP0_ADDR,  1'b1, 8'h3c, 8'h3c},
        {DPT_CMP1_ADDR,  1'b1, 8'hc3, 8'hc3},
        {DPT_MASK_ADDR,  1'b1, 8'h78, 8'h78},
        {DPT_CNT0_ADDR,  1'b1, 8'h12, 8'hff},
        {DPT_CNT1_ADDR,  1'b1, 8'h34, 8'hff},
        {DPT_FLAGS_ADDR, 1'b1, 8'hff, 8'h00},
        {16'hff3b,       1'b1, 8'hff, 8'h00}
    };

    dpt_timer dpt_timer_inst (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .ce       (ce),
        .addr     (addr),
        .wdata    (wdata),
        .wr       (wr),
        .rd       (rd),
        .rdata    (rdata),
        .int_tick (int_tick),
        .ext_clk  (ext_clk),
        .tout     (tout),
        .irq      (irq)
    );

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp)
        begin
            num_errors++;
            $display("Error at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
        @(posedge core_clk);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge core_clk);
        wr <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe edge
    task automatic rd_chk(input logic [15:0] a, input logic [7:0] e);
        @(posedge core_clk);
        rd   <= 1'b1;
        addr <= a;
        @(posedge core_clk);
        rd <= 1'b0;
        #1;
        check(rdata, e);
    endtask

    task automatic tick(input int n);
        repeat (n)
        begin
            @(posedge core_clk);
            int_tick <= 1'b1;
            @(posedge core_clk);
            int_tick <= 1'b0;
        end
    endtask

    // pin pulses last long enough to pass the three-flop sampler
    task automatic pin_pulse(input int idx, input int n);
        repeat (n)
        begin
            @(posedge core_clk);
            ext_clk[idx] <= 1'b1;
            repeat (4) @(posedge core_clk);
            ext_clk[idx] <= 1'b0;
            repeat (4) @(posedge core_clk);
        end
    endtask

    // compares {tout, irq} after the registers settle
    task automatic pins_chk(input logic [7:0] e);
        repeat (2) @(posedge core_clk);
        #1;
        check({5'h0, tout, irq}, e);
    endtask

    task automatic print_verdict;
        $display("checks %0d, mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // ------------------------------------------------------------
    // clock and watchdog
    // ------------------------------------------------------------
    initial
    begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    initial
    begin
        repeat (20000) @(posedge core_clk);
        num_errors++;
        $display("Error at %0t ns: got %h expected %h", $time, 1'b0, 1'b1);
        print_verdict();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        sys_rst = 1'b1;
        ce = 1'b1;
        addr = '0;
        wdata = '0;
        wr = 1'b0;
        rd = 1'b0;
        int_tick = 1'b0;
        ext_clk = 2'h0;
        num_errors = 0;
        compares = 0;
        repeat (6) @(posedge core_clk);
        sys_rst <= 1'b0;
        for (int i = 0; i < 24; i++)
        begin
            if (rows[i].w)
                wr_reg(rows[i].a, rows[i].d);
            rd_chk(rows[i].a, rows[i].e);
        end
        $display("test register table done");

        // timer 0, 8-bit, internal tick
        wr_reg(DPT_RL0_ADDR, 8'h02);
        wr_reg(DPT_CMP0_ADDR, 8'h01);
        wr_reg(DPT_MASK_ADDR, 8'h18);
        wr_reg(DPT_CTRL0_ADDR, 8'h02);
        tick(2);
        rd_chk(DPT_CNT0_ADDR, 8'h02);
        wr_reg(DPT_CTRL0_ADDR, 8'h0c);
        tick(1);
        rd_chk(DPT_CNT0_ADDR, 8'h01);
        rd_chk(DPT_FLAGS_ADDR, 8'h10);
        pins_chk(8'h01);
        tick(1);
        rd_chk(DPT_CNT0_ADDR, 8'h00);
        tick(1);
        rd_chk(DPT_CNT0_ADDR, 8'h02);
        rd_chk(DPT_FLAGS_ADDR, 8'h18);
        pins_chk(8'h03);
        wr_reg(DPT_FLAGS_ADDR, 8'h10);
        rd_chk(DPT_FLAGS_ADDR, 8'h08);
        wr_reg(DPT_FLAGS_ADDR, 8'h00);
        rd_chk(DPT_FLAGS_ADDR, 8'h08);
        wr_reg(DPT_MASK_ADDR, 8'h00);
        pins_chk(8'h02);
        wr_reg(DPT_MASK_ADDR, 8'h08);
        pins_chk(8'h03);
        wr_reg(DPT_FLAGS_ADDR, 8'h08);
        rd_chk(DPT_FLAGS_ADDR, 8'h00);
        wr_reg(DPT_CTRL0_ADDR, 8'h00);
        pins_chk(8'h00);
        $display("test timer0 internal done");

        // timer 1, external pin; timer 0 also counts its own pin
        wr_reg(DPT_RL1_ADDR, 8'h03);
        wr_reg(DPT_CMP1_ADDR, 8'h01);
        wr_reg(DPT_CTRL1_ADDR, 8'h07);
        tick(2);
        rd_chk(DPT_CNT1_ADDR, 8'h03);
        wr_reg(DPT_CTRL0_ADDR, 8'h05);
        pin_pulse(0, 1);
        rd_chk(DPT_CNT0_ADDR, 8'h01);
        rd_chk(DPT_CNT1_ADDR, 8'h03);
        pin_pulse(1, 2);
        rd_chk(DPT_CNT1_ADDR, 8'h01);
        rd_chk(DPT_FLAGS_ADDR, 8'h50);
        pin_pulse(1, 2);
        rd_chk(DPT_CNT1_ADDR, 8'h03);
        rd_chk(DPT_FLAGS_ADDR, 8'h70);
        pins_chk(8'h00);
        wr_reg(DPT_FLAGS_ADDR, 8'h70);
        wr_reg(DPT_CTRL1_ADDR, 8'h02);
        $display("test timer1 external done");

        // cascaded 16-bit count from 0101
        wr_reg(DPT_RL0_ADDR, 8'h01);
        wr_reg(DPT_RL1_ADDR, 8'h01);
        wr_reg(DPT_CTRL1_ADDR, 8'h02);
        wr_reg(DPT_CTRL0_ADDR, 8'h86);
        tick(2);
        rd_chk(DPT_CNT0_ADDR, 8'hff);
        rd_chk(DPT_CNT1_ADDR, 8'h00);
        rd_chk(DPT_FLAGS_ADDR, 8'h08);
        // cascaded load of 0001, 16-bit match at 0000, then 16-bit underflow
        wr_reg(DPT_FLAGS_ADDR, 8'h78);
        wr_reg(DPT_RL1_ADDR, 8'h00);
        wr_reg(DPT_CMP0_ADDR, 8'h00);
        wr_reg(DPT_CMP1_ADDR, 8'h00);
        wr_reg(DPT_CTRL0_ADDR, 8'h8e);
        rd_chk(DPT_CNT0_ADDR, 8'h01);
        rd_chk(DPT_CNT1_ADDR, 8'h00);
        tick(1);
        rd_chk(DPT_FLAGS_ADDR, 8'h50);
        tick(1);
        rd_chk(DPT_FLAGS_ADDR, 8'h78);
        rd_chk(DPT_CNT0_ADDR, 8'h01);
        pins_chk(8'h03);
        wr_reg(DPT_CTRL0_ADDR, 8'h00);
        wr_reg(DPT_FLAGS_ADDR, 8'h78);
        $display("test cascade done");

        // clock enable low drops the write
        @(posedge core_clk);
        ce <= 1'b0;
        wr_reg(DPT_RL0_ADDR, 8'h77);
        ce <= 1'b1;
        rd_chk(DPT_RL0_ADDR, 8'h01);
        $display("test clock enable done");

        // reset in mid-run
        wr_reg(DPT_MASK_ADDR, 8'h78);
        wr_reg(DPT_CTRL0_ADDR, 8'h8c);
        tick(3);
        @(posedge core_clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        sys_rst <= 1'b0;
        for (int i = 0; i < 11; i++)
            rd_chk(rows[i].a, rows[i].e);
        pins_chk(8'h00);
        $display("test mid-run reset done");
        print_verdict();
    end
endmodule
